//--- rtl/rss_pkg.sv
// package for the rotate, subtract and sleep execution slice
// Notes on behaviour
// - rotate right through carry, only carry changes
// - seven-bit file address, destination bit routes result
// - sleep zeroes watchdog counter and its prescaler
// - sleep clears powerdown flag, sets timeout flag
// - sleep stops oscillator, no execution until wake
// - literal minus accumulator into accumulator, flags
// - file minus accumulator, routed, flags updated
// - file minus accumulator minus inverted carry
package rss_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int BUS_AW = 5;
  // register byte offsets
  localparam logic [4:0] INSTR_OFS = 5'h00;
  localparam logic [4:0] ACC_OFS = 5'h04;
  localparam logic [4:0] STATUS_OFS = 5'h08;
  localparam logic [4:0] FPTR_OFS = 5'h0C;
  localparam logic [4:0] FDATA_OFS = 5'h10;
  // instruction word field positions
  localparam int OP_LSB = 0;
  localparam int DEST_BIT = 3;
  localparam int FADDR_LSB = 4;
  localparam int LIT_LSB = 11;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  localparam int ST_SLEEP = 5;
  // operation codes
  localparam logic [2:0] OP_ROTATE_RIGHT_VIA_CARRY = 3'h1;
  localparam logic [2:0] OP_LITERAL_MINUS_ACC = 3'h2;
  localparam logic [2:0] OP_FILE_MINUS_ACC = 3'h3;
  localparam logic [2:0] OP_FILE_MINUS_ACC_BORROW = 3'h4;
  localparam logic [2:0] OP_POWER_DOWN = 3'h5;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] WDT_ZERO = 8'h00;
  localparam logic FLAG_N_RST = 1'b1;
  // decoded instruction word
  typedef struct packed {
    logic [7:0] literal;
    logic [6:0] fileAddr;
    logic dest;
    logic [2:0] op;
  } rss_instr_t;
  // arithmetic flags
  typedef struct packed {
    logic zero;
    logic nibbleCarry;
    logic carry;
  } rss_flags_t;
endpackage

//--- rtl/rss_exec.sv
// execution slice: rotate right, three subtracts, power-down
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
module rss_exec
  import rss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wakeUp,
  output logic watchdogCounterClear,
  output logic watchdogPrescalerClear,
  output logic oscStop,
  output logic timeoutStatusN,
  output logic powerdownStatusN
);

  logic [7:0] fileMem [FILE_DEPTH];
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] acc_ff, nxt_acc;
  rss_flags_t flags_ff, nxt_flags;
  logic pdN_ff, nxt_pdN;
  logic toN_ff, nxt_toN;
  logic sleep_ff, nxt_sleep;
  logic wdtClr_ff, nxt_wdtClr;
  logic prsClr_ff, nxt_prsClr;
  logic [6:0] fptr_ff, nxt_fptr;
  logic wakeMeta_ff, wakeSync_ff;
  logic busReq, wrDone, rdTake;
  rss_instr_t instr;
  logic instrWrite, exec;
  logic isRot, isLit, isSub, isSubB, isSleep;
  logic [7:0] fileVal, minuend, result;
  logic borrowIn;
  logic [8:0] diff;
  logic [4:0] nibDiff;
  logic fileWe;
  logic [6:0] fileWaddr;
  logic [7:0] fileWdata;

  // one wait cycle, then the slave answers
  assign busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ack_ff;
  assign wrDone = avs_write & ack_ff;
  assign rdTake = avs_read & ~ack_ff;
  assign avs_readdata = rdata_ff;

  // instruction decode
  assign instr = rss_instr_t'(avs_writedata[LIT_LSB+7:OP_LSB]);
  assign instrWrite = wrDone & (avs_address == INSTR_OFS) & avs_byteenable[0];
  assign exec = instrWrite & ~sleep_ff;
  assign isRot = exec & (instr.op == OP_ROTATE_RIGHT_VIA_CARRY);
  assign isLit = exec & (instr.op == OP_LITERAL_MINUS_ACC);
  assign isSub = exec & (instr.op == OP_FILE_MINUS_ACC);
  assign isSubB = exec & (instr.op == OP_FILE_MINUS_ACC_BORROW);
  assign isSleep = exec & (instr.op == OP_POWER_DOWN);

  // operand fetch and subtract datapath
  assign fileVal = fileMem[instr.fileAddr];
  assign minuend = isLit ? instr.literal : fileVal;
  assign borrowIn = isSubB & ~flags_ff.carry;
  assign diff = {1'b0, minuend} - {1'b0, acc_ff} - {8'h00, borrowIn};
  assign nibDiff = {1'b0, minuend[3:0]} - {1'b0, acc_ff[3:0]} - {4'h0, borrowIn};

  // result selection
  always_comb
  begin
    if (isRot)
    begin
      result = {flags_ff.carry, fileVal[7:1]};
    end
    else
    begin
      result = diff[7:0];
    end
  end

  // file write port: bus data window or routed result
  always_comb
  begin
    fileWe = 1'b0;
    fileWaddr = fptr_ff;
    fileWdata = avs_writedata[7:0];
    if ((isRot | isSub | isSubB) & instr.dest)
    begin
      fileWe = 1'b1;
      fileWaddr = instr.fileAddr;
      fileWdata = result;
    end
    else if (wrDone & (avs_address == FDATA_OFS) & avs_byteenable[0])
    begin
      fileWe = 1'b1;
    end
  end

  // file register storage
  always_ff @(posedge clk)
  begin
    if (fileWe)
    begin
      fileMem[fileWaddr] <= fileWdata;
    end
  end

  // wake pin synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wakeMeta_ff <= 1'b0;
      wakeSync_ff <= 1'b0;
    end
    else
    begin
      wakeMeta_ff <= wakeUp;
      wakeSync_ff <= wakeMeta_ff;
    end
  end

  // next state of core registers and bus answer
  always_comb
  begin
    nxt_ack = busReq & ~ack_ff;
    nxt_rdata = rdata_ff;
    nxt_acc = acc_ff;
    nxt_flags = flags_ff;
    nxt_pdN = pdN_ff;
    nxt_toN = toN_ff;
    nxt_sleep = sleep_ff;
    nxt_wdtClr = 1'b0;
    nxt_prsClr = 1'b0;
    nxt_fptr = fptr_ff;
    if (rdTake)
    begin
      unique case (avs_address)
        ACC_OFS: nxt_rdata = {24'h000000, acc_ff};
        STATUS_OFS: nxt_rdata = {26'h0000000, sleep_ff, toN_ff, pdN_ff, flags_ff.zero,
          flags_ff.nibbleCarry, flags_ff.carry};
        FPTR_OFS: nxt_rdata = {25'h0000000, fptr_ff};
        FDATA_OFS: nxt_rdata = {24'h000000, fileMem[fptr_ff]};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
    if (wrDone & avs_byteenable[0])
    begin
      unique case (avs_address)
        ACC_OFS: nxt_acc = avs_writedata[7:0];
        STATUS_OFS: nxt_flags = rss_flags_t'(avs_writedata[ST_Z:ST_C]);
        FPTR_OFS: nxt_fptr = avs_writedata[6:0];
        default: nxt_acc = acc_ff;
      endcase
    end
    // rotate: only carry changes
    if (isRot)
    begin
      nxt_flags.carry = fileVal[0];
      if (!instr.dest)
      begin
        nxt_acc = result;
      end
    end
    // subtracts: flags from the difference, borrow in included
    if (isLit | isSub | isSubB)
    begin
      nxt_flags.carry = ~diff[8];
      nxt_flags.nibbleCarry = ~nibDiff[4];
      nxt_flags.zero = (diff[7:0] == 8'h00);
      if (isLit | !instr.dest)
      begin
        nxt_acc = result;
      end
    end
    // power-down entry
    if (isSleep)
    begin
      nxt_wdtClr = 1'b1;
      nxt_prsClr = 1'b1;
      nxt_pdN = 1'b0;
      nxt_toN = 1'b1;
      nxt_sleep = 1'b1;
    end
    else if (sleep_ff & wakeSync_ff)
    begin
      nxt_sleep = 1'b0;
    end
  end

  // core registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      acc_ff <= ACC_RST;
      flags_ff <= '0;
      pdN_ff <= FLAG_N_RST;
      toN_ff <= FLAG_N_RST;
      sleep_ff <= 1'b0;
      wdtClr_ff <= 1'b0;
      prsClr_ff <= 1'b0;
      fptr_ff <= 7'h00;
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      acc_ff <= nxt_acc;
      flags_ff <= nxt_flags;
      pdN_ff <= nxt_pdN;
      toN_ff <= nxt_toN;
      sleep_ff <= nxt_sleep;
      wdtClr_ff <= nxt_wdtClr;
      prsClr_ff <= nxt_prsClr;
      fptr_ff <= nxt_fptr;
    end
  end

  // outputs toward clock and watchdog logic
  assign watchdogCounterClear = wdtClr_ff;
  assign watchdogPrescalerClear = prsClr_ff;
  assign oscStop = sleep_ff;
  assign timeoutStatusN = toN_ff;
  assign powerdownStatusN = pdN_ff;

  // checks
  logic [7:0] pastFile;
  always_ff @(posedge clk)
  begin
    pastFile <= fileVal;
  end

  sequence sleepIssued;
    isSleep;
  endsequence

  sequence sleepEffects;
    wdtClr_ff && prsClr_ff && !pdN_ff && toN_ff && sleep_ff;
  endsequence

  chk_rot_carry: assert property (@(posedge clk) disable iff (rst)
    isRot |=> flags_ff.carry == pastFile[0] && flags_ff.zero == $past(flags_ff.zero))
    else $error("rotate carry wrong");
  chk_rot_route: assert property (@(posedge clk) disable iff (rst)
    isRot && !instr.dest |=> acc_ff == {$past(flags_ff.carry), pastFile[7:1]})
    else $error("rotate result not in accumulator");
  chk_wdt_clear: assert property (@(posedge clk) disable iff (rst)
    sleepIssued |=> wdtClr_ff ##1 !wdtClr_ff && !prsClr_ff)
    else $error("watchdog clear pulse wrong");
  chk_sleep_status: assert property (@(posedge clk) disable iff (rst)
    sleepIssued |=> sleepEffects)
    else $error("power-down status not updated");
  chk_sleep_hold: assert property (@(posedge clk) disable iff (rst)
    sleep_ff && instrWrite |=> $stable(acc_ff) && $stable(flags_ff))
    else $error("instruction ran while asleep");
  chk_lit_sub: assert property (@(posedge clk) disable iff (rst)
    isLit |=> acc_ff == 8'($past(instr.literal) - $past(acc_ff)))
    else $error("literal subtract wrong");
  chk_file_sub: assert property (@(posedge clk) disable iff (rst)
    isSub && !instr.dest |=> acc_ff == 8'(pastFile - $past(acc_ff)))
    else $error("file subtract wrong");
  chk_borrow_sub: assert property (@(posedge clk) disable iff (rst)
    isSubB && !instr.dest |=> acc_ff == 8'(pastFile - $past(acc_ff) - {7'h00, ~$past(flags_ff.carry)}))
    else $error("borrow subtract wrong");
  chk_sub_carry: assert property (@(posedge clk) disable iff (rst)
    isSub |=> flags_ff.carry == ($past(acc_ff) <= pastFile)
      && flags_ff.nibbleCarry == ($past(acc_ff[3:0]) <= pastFile[3:0]))
    else $error("subtract carry wrong");
  chk_sub_zero: assert property (@(posedge clk) disable iff (rst)
    isLit |=> flags_ff.zero == ($past(instr.literal) == $past(acc_ff)))
    else $error("zero flag wrong");

  // further checks on routing, flags and wake
  chk_rot_keep: assert property (@(posedge clk) disable iff (rst)
    isRot |=> flags_ff.nibbleCarry == $past(flags_ff.nibbleCarry))
    else $error("rotate changed nibble carry");
  chk_file_dest: assert property (@(posedge clk) disable iff (rst)
    (isRot || isSub || isSubB) && instr.dest |=> $stable(acc_ff))
    else $error("file result reached accumulator");
  chk_file_route: assert property (@(posedge clk) disable iff (rst)
    isSub && instr.dest |=> fileMem[$past(instr.fileAddr)] == 8'(pastFile - $past(acc_ff)))
    else $error("file subtract not written back");
  chk_lit_flags: assert property (@(posedge clk) disable iff (rst)
    isLit |=> flags_ff.carry == ($past(acc_ff) <= $past(instr.literal))
      && flags_ff.nibbleCarry == ($past(acc_ff[3:0]) <= $past(instr.literal[3:0])))
    else $error("literal subtract carry wrong");
  chk_borrow_zero: assert property (@(posedge clk) disable iff (rst)
    isSubB |=> flags_ff.zero == (8'(pastFile - $past(acc_ff) - {7'h00, ~$past(flags_ff.carry)}) == 8'h00))
    else $error("borrow subtract zero flag wrong");
  chk_clear_cause: assert property (@(posedge clk) disable iff (rst)
    wdtClr_ff || prsClr_ff |-> $past(isSleep))
    else $error("watchdog clear without power-down");
  chk_wake_exit: assert property (@(posedge clk) disable iff (rst)
    sleep_ff && wakeSync_ff |=> !sleep_ff)
    else $error("wake did not end sleep");

endmodule

//--- dv/rss_exec_bench.sv
// self-checking bench for the rotate, subtract and sleep slice
`timescale 1ns/1ps
module rss_exec_bench;
  import rss_pkg::*;
  typedef struct packed {
    logic [2:0] op;
    logic dest;
    logic [6:0] addr;
    logic [7:0] lit;
    logic [7:0] w;
    logic [7:0] f;
    logic [2:0] stIn;
    logic [7:0] res;
    logic [2:0] stOut;
  } rss_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic wakeUp = 1'b0;
  logic [4:0] avsAddress = 5'h00;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0] avsByteenable = 4'hF;
  logic [31:0] avsReaddata, rd;
  logic avsWaitrequest, wdClr, preClr, oscStop, toN, pdN, toFile;
  int errorCnt = 0;
  int nTests = 0;
  int pulses = 0;
  rss_row_t rows [10];
  rss_row_t r;

  rss_exec uut (.clk(clk), .rst(rst), .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .wakeUp(wakeUp), .watchdogCounterClear(wdClr),
    .watchdogPrescalerClear(preClr), .oscStop(oscStop), .timeoutStatusN(toN), .powerdownStatusN(pdN));

  // clock at 50 MHz
  initial
  begin
    forever #10 clk = ~clk;
  end

  // count cycles where both clear pulses stand together
  always @(posedge clk)
  begin
    if (wdClr === 1'b1 && preClr === 1'b1) pulses++;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    nTests++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avsWaitrequest !== 1'b0 && n < 20);
    chk_bit(avsWaitrequest, 1'b0);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_val(rd & m, exp);
  endtask

  task automatic wrap_up();
    if (errorCnt == 0 && nTests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    errorCnt++;
    wrap_up();
  end

  // main sequence: table rows, then reset, sleep and wake cases
  initial
  begin
    rows[0] = {3'h1, 1'h1, 7'h00, 8'h00, 8'h3C, 8'h01, 3'h6, 8'h00, 3'h7};
    rows[1] = {3'h1, 1'h0, 7'h7F, 8'h00, 8'h3C, 8'hE6, 3'h1, 8'hF3, 3'h0};
    rows[2] = {3'h2, 1'h1, 7'h11, 8'h05, 8'h05, 8'hAA, 3'h0, 8'h00, 3'h7};
    rows[3] = {3'h2, 1'h0, 7'h12, 8'h10, 8'h01, 8'hAA, 3'h0, 8'h0F, 3'h1};
    rows[4] = {3'h2, 1'h0, 7'h13, 8'h00, 8'h01, 8'hAA, 3'h7, 8'hFF, 3'h0};
    rows[5] = {3'h3, 1'h1, 7'h20, 8'h00, 8'h80, 8'h80, 3'h0, 8'h00, 3'h7};
    rows[6] = {3'h3, 1'h0, 7'h21, 8'h00, 8'h34, 8'h23, 3'h1, 8'hEF, 3'h0};
    rows[7] = {3'h4, 1'h1, 7'h40, 8'h00, 8'h20, 8'h50, 3'h1, 8'h30, 3'h3};
    rows[8] = {3'h4, 1'h0, 7'h41, 8'h00, 8'h4F, 8'h50, 3'h0, 8'h00, 3'h5};
    rows[9] = {3'h4, 1'h1, 7'h7F, 8'h00, 8'hFF, 8'h00, 3'h0, 8'h00, 3'h4};
    repeat (16) @(posedge clk);
    chk_bit(oscStop | wdClr | preClr, 1'b0);
    chk_bit(toN & pdN, 1'b1);
    rst <= 1'b0;
    rdchk(STATUS_OFS, 32'h38, 32'h18);
    rdchk(5'h14, 32'hFFFFFFFF, 32'h0);
    foreach (rows[i])
    begin
      r = rows[i];
      wr(ACC_OFS, {24'h0, r.w});
      wr(FPTR_OFS, {25'h0, r.addr});
      wr(FDATA_OFS, {24'h0, r.f});
      wr(STATUS_OFS, {29'h0, r.stIn});
      wr(INSTR_OFS, {13'h0, r.lit, r.addr, r.dest, r.op});
      toFile = r.dest && r.op != OP_LITERAL_MINUS_ACC;
      rdchk(ACC_OFS, 32'hFF, {24'h0, toFile ? r.w : r.res});
      rdchk(FDATA_OFS, 32'hFF, {24'h0, toFile ? r.res : r.f});
      rdchk(STATUS_OFS, 32'h7, {29'h0, r.stOut});
    end
    chk_val(pulses, 32'h0);
    wr(ACC_OFS, 32'h42);
    wr(INSTR_OFS, {29'h0, OP_POWER_DOWN});
    @(posedge clk);
    chk_bit(oscStop, 1'b1);
    chk_bit(pdN, 1'b0);
    chk_bit(toN, 1'b1);
    // instruction while asleep must not execute
    wr(INSTR_OFS, {13'h0, 8'h50, 7'h00, 1'b0, OP_LITERAL_MINUS_ACC});
    chk_val(pulses, 32'h1);
    rdchk(ACC_OFS, 32'hFF, 32'h42);
    rdchk(STATUS_OFS, 32'h38, 32'h30);
    wakeUp <= 1'b1;
    for (int k = 0; k < 10 && oscStop !== 1'b0; k++) @(posedge clk);
    chk_bit(oscStop, 1'b0);
    wakeUp <= 1'b0;
    wr(INSTR_OFS, {13'h0, 8'h50, 7'h00, 1'b0, OP_LITERAL_MINUS_ACC});
    rdchk(ACC_OFS, 32'hFF, 32'h0E);
    // second power-down, then a reset in mid-run while asleep
    wr(INSTR_OFS, {29'h0, OP_POWER_DOWN});
    @(posedge clk);
    chk_bit(oscStop, 1'b1);
    chk_bit(pdN, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk_bit(oscStop | wdClr | preClr, 1'b0);
    chk_bit(toN & pdN, 1'b1);
    rst <= 1'b0;
    rdchk(STATUS_OFS, 32'h38, 32'h18);
    chk_val(pulses, 32'h2);
    wrap_up();
  end
endmodule
